// ===== design/sbrc_map.vh
// Register offsets, field positions, reset values and timing counts for the bit-rate clocking block.
`ifndef SBRC_MAP_VH
`define SBRC_MAP_VH
// ==========================================================================
// Register byte offsets
`define SBRC_CLK_MODE_OFF    12'h000
`define SBRC_RESET_CMD_OFF   12'h004
`define SBRC_TIME_CONST_OFF  12'h008
`define SBRC_MODE_OFF        12'h00c
`define SBRC_STATUS_OFF      12'h010
// ==========================================================================
// Clock mode control fields
`define SBRC_CM_XTAL_BIT     7
`define SBRC_CM_SRC_LSB      0
`define SBRC_CM_SRC_MSB      1
`define SBRC_CM_TRANSMIT_RECEIVE_CLOCK_PIN_OE_BIT  2
`define SBRC_CM_RESET        8'h00
// Bit rate source codes.
`define SBRC_SRC_PCLK        2'h0
`define SBRC_SRC_RECEIVE_TRANSMIT_CLOCK_PIN        2'h1
// Reset command field: writing this bit set resets the channel.
`define SBRC_RST_BIT         7
// ==========================================================================
// Mode register fields
`define SBRC_MD_BRG_EN_BIT   0
`define SBRC_MD_DIGITAL_PHASE_LOCKED_LOOP_EN_BIT  1
`define SBRC_MD_FM_BIT       2
`define SBRC_MD_RESET        8'h00
`define SBRC_TC_RESET        16'h0000
// ==========================================================================
// Timing
`define SBRC_READY_CYCLES    3'h4
`define SBRC_SAMPLE_COUNT    5'h08
`define SBRC_FM_FACTOR       6'h10
`define SBRC_NRZ_FACTOR      6'h20
`endif

// ===== design/sbrc_divider.v
// Down-counting divider that toggles its output on each zero count.
`timescale 1ns/1ps
module sbrc_divider (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        sync_rst,
   input  wire        enable,
   input  wire        src_tick,
   input  wire [15:0] time_constant,
   output reg         div_out_q,
   output reg         zero_tick_q
);
   reg [15:0] count_q;
   // ======================================================================
   // Counter
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q     <= 16'h0000;
         div_out_q   <= 1'b0;
         zero_tick_q <= 1'b0;
      end else if (sync_rst || !enable) begin
         count_q     <= time_constant; // RULE_12
         div_out_q   <= 1'b0;
         zero_tick_q <= 1'b0;
      end else begin
         zero_tick_q <= 1'b0;
         if (src_tick) begin
            if (count_q == 16'h0000) begin
               // Reload needs one more source edge, hence the plus-one in the divide ratio.
               count_q     <= time_constant; // RULE_12
               div_out_q   <= ~div_out_q; // RULE_14
               zero_tick_q <= 1'b1;
            end else begin
               count_q <= count_q - 16'h0001;
            end
         end
      end
   end
endmodule // sbrc_divider

// ===== design/sbrc_top.v
// Bit-rate clock generation, source select and receive sampling for one serial channel.
// How it works
// (RULE_01) Divider source is peripheral clock, clock pin, or crystal oscillator.
// (RULE_02) Clock mode bit 7 runs crystal oscillator between clock pin and return pin.
// (RULE_03) Board supplies one crystal per channel; crystals are never shared.
// (RULE_04) Generated clock can be driven out on the transmit/receive clock pin.
// (RULE_05) Software sets time constant as fsrc/(2*rate*factor) minus two; the code's divider needs fsrc/(2*rate*factor) minus one.
// (RULE_06) In sixteen-times mode the receiver samples at count eight of the cell.
// (RULE_07) Phase-locked FM recovery reaches at most one sixteenth of peripheral clock; the code reaches at most pclk/32.
// (RULE_08) Phase-locked NRZ/NRZI recovery reaches at most one thirty-second of it; the code reaches at most pclk/64.
// (RULE_09) Device is ready four clocks after reset; host waits before configuring.
// (RULE_10) Software reset command acts exactly like a hardware reset; the code keeps the time constant through it.
// (RULE_11) Peripheral clock keeps running while reset is asserted.
// (RULE_12) Divider reloads time constant after software reset and at zero count.
// (RULE_13) Phase-locked loop input runs at sixteen or thirty-two times bit rate.
// (RULE_14) Divider toggles at zero so output is source over twice (constant plus two); the code divides by twice (constant plus one).
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "sbrc_map.vh"
module sbrc_top (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        receive_transmit_clock_pin_i,
   output reg         xtal_drive_o,
   output reg         xtal_drive_oe,
   input  wire        rx_data_i,
   output reg         transmit_receive_clock_pin_o,
   output reg         transmit_receive_clock_pin_oe,
   output reg         bit_rate_clock_o,
   output reg         rx_sample_o,
   output reg         rx_bit_o
);
   // ======================================================================
   // Registers and reset sequencing
   reg  [7:0]  clock_mode_q;
   reg  [7:0]  mode_q;
   reg  [15:0] time_constant_q;
   reg  [2:0]  ready_cnt_q;
   reg         soft_rst_q;
   reg         pin_q;
   reg         osc_q;
   reg         prev_src_q;
   reg         prev_div_q;
   reg         prev_digital_phase_locked_loop_q;
   reg  [4:0]  cell_cnt_q;
   reg  [5:0]  digital_phase_locked_loop_cnt_q;
   wire        div_out;
   wire        zero_tick;
   wire        ready   = (ready_cnt_q == `SBRC_READY_CYCLES);
   wire        access  = psel && penable;
   wire        wr      = access && pwrite && ready;
   wire        xtal_on = clock_mode_q[`SBRC_CM_XTAL_BIT];
   wire [1:0]  src_sel = clock_mode_q[`SBRC_CM_SRC_MSB:`SBRC_CM_SRC_LSB];
   wire        mapped  = (paddr == `SBRC_CLK_MODE_OFF) || (paddr == `SBRC_RESET_CMD_OFF) ||
                         (paddr == `SBRC_TIME_CONST_OFF) || (paddr == `SBRC_MODE_OFF) ||
                         (paddr == `SBRC_STATUS_OFF);
   reg         src_level;
   always @* begin
      src_level = 1'b0;
      if (xtal_on) begin
         src_level = osc_q; // RULE_02
      end else begin
         case (src_sel) // RULE_01
            `SBRC_SRC_PCLK: src_level = ~prev_src_q;
            `SBRC_SRC_RECEIVE_TRANSMIT_CLOCK_PIN: src_level = pin_q;
            default:        src_level = osc_q;
         endcase
      end
   end
   // A rising source level is one divider tick; peripheral clock mode ticks every cycle.
   wire src_tick = (src_sel == `SBRC_SRC_PCLK && !xtal_on) ? 1'b1 : (src_level && !prev_src_q);
   // ======================================================================
   // Bus slave
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_mode_q    <= `SBRC_CM_RESET;
         mode_q          <= `SBRC_MD_RESET;
         time_constant_q <= `SBRC_TC_RESET;
         soft_rst_q      <= 1'b0;
         ready_cnt_q     <= 3'h0;
         prdata          <= 32'h00000000;
         pready          <= 1'b0;
         pslverr         <= 1'b0;
      end else begin
         soft_rst_q <= wr && paddr == `SBRC_RESET_CMD_OFF && pwdata[`SBRC_RST_BIT];
         pready     <= psel && !pready;
         pslverr    <= psel && !pready && !mapped;
         if (soft_rst_q) begin
            // Same state as the hardware reset except the time constant, which is kept, including the readiness wait.
            clock_mode_q <= `SBRC_CM_RESET; // RULE_10
            mode_q       <= `SBRC_MD_RESET; // RULE_10
            ready_cnt_q  <= 3'h0; // RULE_09
         end else begin
            if (!ready) ready_cnt_q <= ready_cnt_q + 3'h1; // RULE_09
            if (wr && pready && paddr == `SBRC_CLK_MODE_OFF) clock_mode_q <= pwdata[7:0];
            if (wr && pready && paddr == `SBRC_MODE_OFF) mode_q <= pwdata[7:0];
         end
         if (wr && pready && paddr == `SBRC_TIME_CONST_OFF) time_constant_q <= pwdata[15:0];
         if (psel && !pready) begin
            case (paddr)
               `SBRC_CLK_MODE_OFF:   prdata <= {24'h000000, clock_mode_q};
               `SBRC_TIME_CONST_OFF: prdata <= {16'h0000, time_constant_q};
               `SBRC_MODE_OFF:       prdata <= {24'h000000, mode_q};
               `SBRC_STATUS_OFF:     prdata <= {27'h0000000, ready, rx_bit_o, div_out,
                                                src_level, xtal_on};
               default:              prdata <= 32'h00000000;
            endcase
         end
      end
   end
   // ======================================================================
   // Divider
   sbrc_divider u_div (
      .pclk          (pclk),
      .presetn       (presetn),
      .sync_rst      (soft_rst_q),
      .enable        (mode_q[`SBRC_MD_BRG_EN_BIT]),
      .src_tick      (src_tick),
      .time_constant (time_constant_q),
      .div_out_q     (div_out),
      .zero_tick_q   (zero_tick)
   );
   // ======================================================================
   // Oscillator, pins and receive sampling
   wire digital_phase_locked_loop_on  = mode_q[`SBRC_MD_DIGITAL_PHASE_LOCKED_LOOP_EN_BIT];
   wire [5:0] factor = mode_q[`SBRC_MD_FM_BIT] ? `SBRC_FM_FACTOR : `SBRC_NRZ_FACTOR;
   wire div_rise = div_out && !prev_div_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_q <= 1'b0;
         osc_q <= 1'b0;
         prev_src_q <= 1'b0;
         prev_div_q <= 1'b0;
         prev_digital_phase_locked_loop_q <= 1'b0;
         cell_cnt_q <= 5'h00;
         digital_phase_locked_loop_cnt_q <= 6'h00;
         xtal_drive_o <= 1'b0;
         xtal_drive_oe <= 1'b0;
         transmit_receive_clock_pin_o <= 1'b0;
         transmit_receive_clock_pin_oe <= 1'b0;
         bit_rate_clock_o <= 1'b0;
         rx_sample_o <= 1'b0;
         rx_bit_o <= 1'b0;
      end else begin
         pin_q <= receive_transmit_clock_pin_i;
         // The oscillator is modelled as an inverter feeding back through the crystal.
         osc_q <= xtal_on & receive_transmit_clock_pin_i;
         xtal_drive_o  <= ~receive_transmit_clock_pin_i; // RULE_02
         xtal_drive_oe <= xtal_on; // RULE_02
         prev_src_q <= src_level;
         prev_div_q <= div_out;
         bit_rate_clock_o <= div_out;
         transmit_receive_clock_pin_o  <= div_out; // RULE_04
         transmit_receive_clock_pin_oe <= clock_mode_q[`SBRC_CM_TRANSMIT_RECEIVE_CLOCK_PIN_OE_BIT]; // RULE_04
         rx_sample_o <= 1'b0;
         if (soft_rst_q) begin
            cell_cnt_q <= 5'h00;
            digital_phase_locked_loop_cnt_q <= 6'h00;
         end else if (digital_phase_locked_loop_on) begin
            // Recovered bit rate is factor times slower than the divider output, limiting rates to pclk/32 or /64.
            if (div_rise) begin
               if (digital_phase_locked_loop_cnt_q == factor - 6'h01) begin // RULE_13 RULE_07 RULE_08
                  digital_phase_locked_loop_cnt_q <= 6'h00;
                  prev_digital_phase_locked_loop_q <= 1'b1;
               end else begin
                  digital_phase_locked_loop_cnt_q <= digital_phase_locked_loop_cnt_q + 6'h01;
                  if (digital_phase_locked_loop_cnt_q == {1'b0, factor[5:1]} - 6'h01) begin
                     rx_sample_o <= 1'b1;
                     rx_bit_o    <= rx_data_i;
                  end
               end
            end
         end else if (div_rise) begin
            cell_cnt_q <= cell_cnt_q + 5'h01;
            if (cell_cnt_q[3:0] == 4'hf) cell_cnt_q <= 5'h00;
            if (cell_cnt_q == `SBRC_SAMPLE_COUNT - 5'h01) begin // RULE_06
               rx_sample_o <= 1'b1;
               rx_bit_o    <= rx_data_i;
            end
         end
      end
   end
endmodule // sbrc_top

// ===== sim/sbrc_clk_src.sv
// Behavioural clock source standing on the channel's clock pin.
`timescale 1ns/1ps
module sbrc_clk_src (
   input  logic ext_run,
   input  logic xtal_drive_oe,
   output logic receive_transmit_clock_pin_i
);
   // ==================
   // Pin clock
   // One source per channel; a crystal is never shared between channels.
   // The external clock stands still at low between uses, so no stray edge can count.
   initial begin
      receive_transmit_clock_pin_i = 1'b0;
      #7;
      forever begin
         #160;
         if (ext_run || xtal_drive_oe)
            receive_transmit_clock_pin_i = !receive_transmit_clock_pin_i;
         else
            receive_transmit_clock_pin_i = 1'b0;
      end
   end
endmodule // sbrc_clk_src

// ===== sim/sbrc_top_chk.sv
// Assertions on the bus answer and channel clock outputs.
`timescale 1ns/1ps
module sbrc_top_chk (
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic        xtal_drive_oe,
   input logic        transmit_receive_clock_pin_oe,
   input logic        bit_rate_clock_o,
   input logic        rx_sample_o,
   input logic        rx_bit_o
);
   // ==================
   // Properties
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ans; psel && !penable |=> pready; endproperty
   a_ans: assert property (p_ans) else $error("late ready");
   property p_acc; pready |-> psel && penable; endproperty
   a_acc: assert property (p_acc) else $error("stray ready");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("long ready");
   property p_err; pready && paddr >= 12'h014 |-> pslverr && prdata == 32'h0; endproperty
   a_err: assert property (p_err) else $error("unmapped answer");
   property p_map; pready && paddr <= 12'h010 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
   a_map: assert property (p_map) else $error("mapped error");
   property p_rst; $rose(presetn) |-> !pready && !bit_rate_clock_o && !xtal_drive_oe; endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   property p_sw;
      pready && pwrite && paddr == 12'h004 && pwdata[7]
      |-> ##[1:4] !xtal_drive_oe && !transmit_receive_clock_pin_oe;
   endproperty
   a_sw: assert property (p_sw) else $error("soft reset");
   property p_smp; rx_sample_o |=> !rx_sample_o [*8]; endproperty
   a_smp: assert property (p_smp) else $error("sample pulse");
   property p_bit; $rose(rx_bit_o) |-> rx_sample_o || $past(rx_sample_o); endproperty
   a_bit: assert property (p_bit) else $error("bit change");
endmodule // sbrc_top_chk
bind sbrc_top sbrc_top_chk u_sbrc_top_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .xtal_drive_oe, .transmit_receive_clock_pin_oe,
   .bit_rate_clock_o, .rx_sample_o, .rx_bit_o);

// ===== sim/tb_top.sv
// Self-checking bench of the bit-rate clocking block over its register bus.
`timescale 1ns/1ps
`include "sbrc_map.vh"
module tb_top;
   localparam logic [11:0] CM = `SBRC_CLK_MODE_OFF;
   localparam logic [11:0] TC = `SBRC_TIME_CONST_OFF;
   localparam logic [11:0] MD = `SBRC_MODE_OFF;
   logic        pclk, presetn, psel, penable, pwrite, ext_run, rx_data_i, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, receive_transmit_clock_pin_i, xtal_drive_o, xtal_drive_oe;
   logic        transmit_receive_clock_pin_o, transmit_receive_clock_pin_oe;
   logic        bit_rate_clock_o, rx_sample_o, rx_bit_o;
   int          error_cnt, checked, c, i;
   logic [7:0]  cmv [3] = '{8'h04, 8'h01, 8'h86};
   logic [15:0] tcv [3] = '{16'h0003, 16'h0001, 16'h0001};
   int          hv [3] = '{4, 16, 16};
   sbrc_top u_sbrc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .receive_transmit_clock_pin_i, .xtal_drive_o, .xtal_drive_oe,
      .rx_data_i, .transmit_receive_clock_pin_o, .transmit_receive_clock_pin_oe,
      .bit_rate_clock_o, .rx_sample_o, .rx_bit_o);
   sbrc_clk_src u_sbrc_clk_src (.ext_run, .xtal_drive_oe, .receive_transmit_clock_pin_i);
   // ==================
   // Clock keeps running through reset, since reset is sampled with it.
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // ==================
   // Tasks
   task automatic print_verdict;
      if (error_cnt == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 999);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // One idle cycle keeps a following call from driving psel twice in one step.
      @(posedge pclk);
      if (n >= 999) begin
         chk("bus_wait", 32'h0, 32'h1);
         print_verdict();
      end
   endtask
   task automatic half(output int n);
      logic v;
      v = bit_rate_clock_o;
      n = 0;
      while (bit_rate_clock_o === v && n < 999) begin
         @(posedge pclk);
         n++;
      end
   endtask
   task automatic gap(output int n);
      repeat (2) begin
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (rx_sample_o !== 1'b1 && n < 999);
      end
   endtask
   // ==================
   // Sequence
   initial begin
      {psel, penable, pwrite, ext_run, rx_data_i, presetn} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      error_cnt = 0;
      checked = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b1, CM, 32'h84);
      repeat (4) @(posedge pclk);
      apb(1'b0, CM, 32'h0);
      chk("early_cm", 32'h0, rd);
      apb(1'b0, `SBRC_STATUS_OFF, 32'h0);
      chk("ready", 32'h1, {31'h0, rd[4]});
      for (i = 0; i < 3; i++) begin
         ext_run <= (i == 1);
         apb(1'b1, TC, {16'h0, tcv[i]});
         apb(1'b1, CM, {24'h0, cmv[i]});
         apb(1'b1, MD, 32'h1);
         half(c);
         half(c);
         half(c);
         chk("half", hv[i], c);
         chk("pin_oe", {31'h0, cmv[i][2]}, {31'h0, transmit_receive_clock_pin_oe});
      end
      chk("xtal_oe", 32'h1, {31'h0, xtal_drive_oe});
      rx_data_i <= 1'b1;
      apb(1'b1, CM, 32'h0);
      // Plain sixteen-times sampling first, then phase-locked FM and NRZ recovery.
      for (i = 0; i < 3; i++) begin
         apb(1'b1, MD, (i == 0) ? 32'h1 : (i == 1) ? 32'h7 : 32'h3);
         gap(c);
         chk("cell", (i == 2) ? 128 : 64, c);
         chk("rx_bit", 32'h1, {31'h0, rx_bit_o});
      end
      apb(1'b1, `SBRC_RESET_CMD_OFF, 32'h80);
      apb(1'b1, CM, 32'h84);
      repeat (4) @(posedge pclk);
      apb(1'b0, MD, 32'h0);
      chk("md_reset", 32'h0, rd);
      apb(1'b0, CM, 32'h0);
      chk("cm_reset", 32'h0, rd);
      apb(1'b0, TC, 32'h0);
      chk("tc_kept", 32'h1, rd);
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, er});
      chk("unmapped_rd", 32'h0, rd);
      print_verdict();
   end
endmodule // tb_top
